// ==== rtl/adc_irq_fifo_readout.sv ====
/*
 * Acquisition control: conversion triggering, channel scan, sample store,
 * two selectable interrupt lines and the register port.
 * Assumes an external converter answering conv_start with a conv_done pulse.
 */
// Function
// - First line source: 0 off, 1 conversion done, 2 FIFO half full.
// - Second line source: 0 off, 1 pacer tick, 2 external input.
// - A pending request stays until software clears it; no new one meanwhile.
// - Software reads each line's pending state separately.
// - Half-full flag is readable; host then reads one 512-word block.
// - A full store marks overrun and later samples are dropped.
// - Samples are read through a 16-bit and a 32-bit data port.
// - 16-bit port holds the sample in bits 0 to 11.
// - 32-bit port holds sample in bits 0-11, channel in bits 16-20.
// - Scan steps channels 0 up to the last channel then wraps.
// - Software conversion shows when its value is ready.
// - Pacer is two cascaded dividers; a zero divider stops triggers.
// - A software trigger while idle starts exactly one conversion into the data port.
// - A store reset discards all samples; host issues it before a run.
`timescale 1ns/1ps
`default_nettype none
module adc_irq_fifo_readout #(
    parameter int FIFO_DEPTH = adc_readout_pkg::FIFO_DEPTH,
    parameter int DIV_W      = adc_readout_pkg::DIV_W
) (
    input  wire logic        clock,
    input  wire logic        sys_rst,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    output logic             conv_start,
    output logic      [4:0]  conv_channel,
    input  wire logic        conv_done,
    input  wire logic [11:0] conv_result,
    input  wire logic        ext_irq_in,
    output logic             irq_out
);
    localparam int CW = $clog2(FIFO_DEPTH + 1);
    localparam int FW = adc_readout_pkg::CHAN_W + adc_readout_pkg::SAMPLE_W;

    logic [10:0]      ctrl_r;
    logic [DIV_W-1:0] div_one_r;
    logic [DIV_W-1:0] div_two_r;
    logic [3:0]       irq_stat_r;
    logic [3:0]       irq_mask_r;
    logic [4:0]       ch_r;
    logic             overrun_r;
    logic             src1_q;
    logic             src2_q;
    logic             conv_start_r;
    logic [31:0]      rdata_r;
    adc_readout_pkg::conv_state_e state_r;

    logic [FW-1:0]    fifo_head;
    logic [CW-1:0]    fifo_count;
    logic             fifo_full;
    logic             fifo_empty;
    logic             stage_one_tick;
    logic             pacer_tick;

    // Address decode
    wire hit_d16    = (reg_addr == adc_readout_pkg::OFS_DATA16);
    wire hit_d32    = (reg_addr == adc_readout_pkg::OFS_DATA32);
    wire hit_ctrl   = (reg_addr == adc_readout_pkg::OFS_CTRL);
    wire hit_div1   = (reg_addr == adc_readout_pkg::OFS_DIV_ONE);
    wire hit_div2   = (reg_addr == adc_readout_pkg::OFS_DIV_TWO);
    wire hit_status = (reg_addr == adc_readout_pkg::OFS_STATUS);
    wire hit_cmd    = (reg_addr == adc_readout_pkg::OFS_CMD);
    wire hit_istat  = (reg_addr == adc_readout_pkg::OFS_IRQ_STAT);
    wire hit_imask  = (reg_addr == adc_readout_pkg::OFS_IRQ_MASK);

    wire wr_ctrl  = reg_wr & hit_ctrl;
    wire wr_istat = reg_wr & hit_istat;

    // Control fields
    wire       scan_en  = ctrl_r[adc_readout_pkg::CTRL_SCAN_BIT];
    wire [4:0] last_scan_channel = ctrl_r[adc_readout_pkg::CTRL_CH_LSB +: 5];
    wire [1:0] first_irq_source_select  = ctrl_r[adc_readout_pkg::CTRL_SEL1_LSB +: 2];
    wire [1:0] second_irq_source_select = ctrl_r[adc_readout_pkg::CTRL_SEL2_LSB +: 2];
    wire       pacer_en = ctrl_r[adc_readout_pkg::CTRL_PACER_BIT];

    // Commands
    wire soft_trig = reg_wr & hit_cmd & reg_wdata[adc_readout_pkg::CMD_TRIG_BIT];
    wire fifo_clr  = reg_wr & hit_cmd & reg_wdata[adc_readout_pkg::CMD_FIFO_CLR_BIT];

    // Pacer: second stage counts ticks of the first
    tick_divider #(.W(DIV_W)) u_stage_one (
        .clock   (clock),
        .sys_rst (sys_rst),
        .step    (1'b1),
        .divisor (div_one_r),
        .tick    (stage_one_tick)
    );
    tick_divider #(.W(DIV_W)) u_stage_two (
        .clock   (clock),
        .sys_rst (sys_rst),
        .step    (stage_one_tick),
        .divisor (div_two_r),
        .tick    (pacer_tick)
    );

    // Triggers arriving while a conversion is under way are dropped
    wire idle      = (state_r == adc_readout_pkg::CONV_IDLE);
    wire pacer_trig = pacer_en & pacer_tick;
    wire start     = idle & (soft_trig | pacer_trig);
    wire done_evt  = (state_r == adc_readout_pkg::CONV_BUSY) & conv_done;
    wire push      = done_evt & ~fifo_full;
    wire pop       = reg_rd & (hit_d16 | hit_d32) & ~fifo_empty;
    wire half_full = (fifo_count >= CW'(adc_readout_pkg::BLOCK_WORDS));

    // Channel sequence
    wire [4:0] ch_nxt = ~scan_en ? last_scan_channel :
                        (ch_r >= last_scan_channel) ? 5'h00 : ch_r + 5'h01;

    sample_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) u_store (
        .clock   (clock),
        .sys_rst (sys_rst),
        .clear   (fifo_clr),
        .push    (push),
        .din     ({ch_r, conv_result}),
        .pop     (pop),
        .head    (fifo_head),
        .count   (fifo_count),
        .full    (fifo_full),
        .empty   (fifo_empty)
    );

    // Interrupt sources
    wire src1 = (first_irq_source_select == adc_readout_pkg::SEL_ONE) ? done_evt :
                (first_irq_source_select == adc_readout_pkg::SEL_TWO) ? half_full :
                1'b0;
    wire src2 = (second_irq_source_select == adc_readout_pkg::SEL_ONE) ? pacer_tick :
                (second_irq_source_select == adc_readout_pkg::SEL_TWO) ? ext_irq_in :
                1'b0;
    wire rise1 = src1 & ~src1_q;
    wire rise2 = src2 & ~src2_q;

    wire [3:0] irq_set = {push, done_evt & fifo_full, rise2, rise1};
    wire [3:0] irq_w1c = wr_istat ? reg_wdata[3:0] : 4'h0;
    // Set wins over a clear in the same cycle so no event is lost
    wire [3:0] irq_stat_nxt = (irq_stat_r & ~irq_w1c) | irq_set;

    assign irq_out = |(irq_stat_r & irq_mask_r);

    // Read data; an empty store reads as zero
    wire [11:0] head_val = fifo_empty ? 12'h000 : fifo_head[11:0];
    wire [4:0]  head_ch  = fifo_empty ? 5'h00 : fifo_head[16:12];
    wire [31:0] d16_word = {20'h00000, head_val};
    wire [31:0] d32_word = {11'h000, head_ch, 4'h0, head_val};
    wire [31:0] stat_word = {24'h000000, ~idle, ~fifo_empty, overrun_r, fifo_empty,
                             fifo_full, half_full, irq_stat_r[1], irq_stat_r[0]};
    wire [31:0] rd_mux = hit_d16    ? d16_word :
                         hit_d32    ? d32_word :
                         hit_ctrl   ? {21'h000000, ctrl_r} :
                         hit_div1   ? 32'(div_one_r) :
                         hit_div2   ? 32'(div_two_r) :
                         hit_status ? stat_word :
                         hit_istat  ? {28'h0000000, irq_stat_r} :
                         hit_imask  ? {28'h0000000, irq_mask_r} :
                         32'h00000000;

    assign reg_rdata    = rdata_r;
    assign conv_start   = conv_start_r;
    assign conv_channel = ch_r;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ctrl_r     <= adc_readout_pkg::CTRL_RESET;
            div_one_r  <= DIV_W'(adc_readout_pkg::DIV_RESET);
            div_two_r  <= DIV_W'(adc_readout_pkg::DIV_RESET);
            irq_mask_r <= adc_readout_pkg::IRQ_MASK_RESET;
        end else if (reg_wr) begin
            if (hit_ctrl)  ctrl_r     <= reg_wdata[10:0];
            if (hit_div1)  div_one_r  <= reg_wdata[DIV_W-1:0];
            if (hit_div2)  div_two_r  <= reg_wdata[DIV_W-1:0];
            if (hit_imask) irq_mask_r <= reg_wdata[3:0];
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            irq_stat_r <= adc_readout_pkg::IRQ_STAT_RESET;
            src1_q     <= 1'b0;
            src2_q     <= 1'b0;
            overrun_r  <= 1'b0;
            rdata_r    <= 32'h00000000;
        end else begin
            irq_stat_r <= irq_stat_nxt;
            src1_q     <= src1;
            src2_q     <= src2;
            overrun_r  <= (done_evt & fifo_full) | (overrun_r & ~fifo_clr);
            rdata_r    <= reg_rd ? rd_mux : 32'h00000000;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_r      <= adc_readout_pkg::CONV_IDLE;
            conv_start_r <= 1'b0;
            ch_r         <= 5'h00;
        end else begin
            conv_start_r <= start;
            case (state_r)
                adc_readout_pkg::CONV_IDLE: begin
                    if (start) state_r <= adc_readout_pkg::CONV_BUSY;
                end
                adc_readout_pkg::CONV_BUSY: begin
                    if (conv_done) state_r <= adc_readout_pkg::CONV_IDLE;
                end
                default: state_r <= adc_readout_pkg::CONV_IDLE;
            endcase
            if (wr_ctrl && idle) begin
                ch_r <= reg_wdata[adc_readout_pkg::CTRL_SCAN_BIT] ? 5'h00
                        : reg_wdata[adc_readout_pkg::CTRL_CH_LSB +: 5];
            end else if (done_evt) begin
                ch_r <= ch_nxt;
            end
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    AST_SEL1_OFF: assert property (
        (first_irq_source_select == adc_readout_pkg::SEL_OFF && !irq_stat_r[0])
        |=> !irq_stat_r[0]) else $error("first line set while disabled");

    AST_LINE1_HALF: assert property (
        (first_irq_source_select == adc_readout_pkg::SEL_TWO && half_full && !src1_q)
        |=> irq_stat_r[0]) else $error("half full did not raise first line");

    AST_LINE1_DONE: assert property (
        (first_irq_source_select == adc_readout_pkg::SEL_ONE && done_evt && !src1_q)
        |=> irq_stat_r[0]) else $error("conversion done did not raise first line");

    AST_SEL2_OFF: assert property (
        (second_irq_source_select == adc_readout_pkg::SEL_OFF && !irq_stat_r[1])
        |=> !irq_stat_r[1]) else $error("second line set while disabled");

    AST_LINE2_TICK: assert property (
        (second_irq_source_select == adc_readout_pkg::SEL_ONE && pacer_tick && !src2_q)
        |=> irq_stat_r[1]) else $error("pacer tick did not raise second line");

    AST_LINE2_EXT: assert property (
        (second_irq_source_select == adc_readout_pkg::SEL_TWO && ext_irq_in && !src2_q)
        |=> irq_stat_r[1]) else $error("external input did not raise second line");

    AST_PENDING_HOLDS: assert property (
        (irq_stat_r[0] && !(wr_istat && reg_wdata[0])) |=> irq_stat_r[0])
        else $error("pending request dropped without clear");

    AST_STATUS_READ: assert property (
        (reg_rd && hit_status) |=> reg_rdata[1:0] == $past(irq_stat_r[1:0]))
        else $error("pending bits misreported");

    AST_HALF_FLAG: assert property (
        (reg_rd && hit_status) |=> reg_rdata[adc_readout_pkg::ST_HALF] ==
        ($past(fifo_count) >= CW'(adc_readout_pkg::BLOCK_WORDS)))
        else $error("half-full flag wrong");

    // A pop in the same cycle may lower the count; a dropped sample never raises it
    AST_OVERRUN: assert property (
        (done_evt && fifo_full && !fifo_clr) |=> overrun_r &&
        fifo_count == $past(fifo_count) - CW'($past(pop)))
        else $error("overrun not flagged or sample stored");

    AST_RDATA_IDLE: assert property (
        !reg_rd |=> reg_rdata == 32'h00000000) else $error("read data not zero when idle");

    AST_D16_FMT: assert property (
        (reg_rd && hit_d16 && !fifo_empty) |=> reg_rdata[31:12] == 20'h00000 &&
        reg_rdata[11:0] == $past(fifo_head[11:0])) else $error("16-bit word malformed");

    AST_D32_FMT: assert property (
        (reg_rd && hit_d32 && !fifo_empty) |=> reg_rdata[20:16] == $past(fifo_head[16:12])
        && reg_rdata[15:12] == 4'h0) else $error("32-bit word malformed");

    AST_SCAN_WRAP: assert property (
        (done_evt && scan_en && ch_r >= last_scan_channel && !wr_ctrl) |=> ch_r == 5'h00)
        else $error("scan did not wrap");

    AST_CH_FIXED: assert property (
        (done_evt && !scan_en && !wr_ctrl) |=> ch_r == last_scan_channel)
        else $error("fixed channel not kept");

    AST_PACER_ZERO: assert property (
        (div_one_r == '0 || div_two_r == '0) |-> !pacer_tick)
        else $error("pacer ticked with a zero divider");

    AST_TRIG_START: assert property (
        (soft_trig && idle) |=> conv_start ##1 !conv_start)
        else $error("software trigger did not give one start pulse");

    AST_START_BUSY: assert property (
        start |=> conv_start && state_r == adc_readout_pkg::CONV_BUSY)
        else $error("start did not enter busy");

    AST_CLR_EMPTY: assert property (
        fifo_clr |=> fifo_empty) else $error("store reset left samples");

    AST_IRQ_OUT: assert property (
        (irq_stat_r[0] && irq_mask_r[0]) |-> irq_out) else $error("irq output low");

    AST_IRQ_OUT_LOW: assert property (
        (irq_stat_r & irq_mask_r) == 4'h0 |-> !irq_out) else $error("irq output high");
endmodule
`default_nettype wire

// ==== rtl/adc_readout_pkg.sv ====
/*
 * Shared constants for the acquisition readout block: register offsets,
 * field positions, reset values, source selects and converter states.
 * Assumes byte addresses on a plain register port with 32-bit data.
 */
package adc_readout_pkg;
    localparam logic [7:0] OFS_DATA16   = 8'h00;
    localparam logic [7:0] OFS_DATA32   = 8'h04;
    localparam logic [7:0] OFS_CTRL     = 8'h08;
    localparam logic [7:0] OFS_DIV_ONE  = 8'h0C;
    localparam logic [7:0] OFS_DIV_TWO  = 8'h10;
    localparam logic [7:0] OFS_STATUS   = 8'h14;
    localparam logic [7:0] OFS_CMD      = 8'h18;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h1C;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h20;

    localparam int CTRL_W          = 11;
    localparam int CTRL_SCAN_BIT   = 0;
    localparam int CTRL_CH_LSB     = 1;
    localparam int CTRL_SEL1_LSB   = 6;
    localparam int CTRL_SEL2_LSB   = 8;
    localparam int CTRL_PACER_BIT  = 10;
    localparam logic [10:0] CTRL_RESET = 11'h000;

    localparam logic [1:0] SEL_OFF = 2'h0;
    localparam logic [1:0] SEL_ONE = 2'h1;
    localparam logic [1:0] SEL_TWO = 2'h2;

    localparam int CMD_TRIG_BIT     = 0;
    localparam int CMD_FIFO_CLR_BIT = 1;

    localparam int IRQ_W        = 4;
    localparam int IRQ_LINE1    = 0;
    localparam int IRQ_LINE2    = 1;
    localparam int IRQ_OVERRUN  = 2;
    localparam int IRQ_READY    = 3;
    localparam logic [3:0] IRQ_STAT_RESET = 4'h0;
    localparam logic [3:0] IRQ_MASK_RESET = 4'h3;

    localparam int ST_HALF = 2;

    localparam int SAMPLE_W    = 12;
    localparam int CHAN_W      = 5;
    localparam int CHAN_LSB    = 16;
    localparam int FIFO_DEPTH  = 1024;
    localparam int BLOCK_WORDS = 512;
    localparam int DIV_W       = 16;
    localparam logic [15:0] DIV_RESET = 16'h0000;

    typedef enum logic [1:0] {
        CONV_IDLE = 2'b01,
        CONV_BUSY = 2'b10
    } conv_state_e;
endpackage

// ==== rtl/sample_fifo.sv ====
/*
 * Sample store: first-in first-out memory with occupancy count.
 * Assumes the writer never pushes while full and the reader never pops while empty.
 */
`timescale 1ns/1ps
`default_nettype none
module sample_fifo #(
    parameter int WIDTH = 17,
    parameter int DEPTH = 1024
) (
    input  wire logic                       clock,
    input  wire logic                       sys_rst,
    input  wire logic                       clear,
    input  wire logic                       push,
    input  wire logic [WIDTH-1:0]           din,
    input  wire logic                       pop,
    output logic      [WIDTH-1:0]           head,
    output logic      [$clog2(DEPTH+1)-1:0] count,
    output logic                            full,
    output logic                            empty
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wptr_r;
    logic [AW-1:0]    rptr_r;
    logic [CW-1:0]    count_r;

    assign head  = mem[rptr_r];
    assign count = count_r;
    assign full  = (count_r == CW'(DEPTH));
    assign empty = (count_r == '0);

    always_ff @(posedge clock) begin
        if (push) begin
            mem[wptr_r] <= din;
        end
    end

    // Clear drops every stored sample at once
    always_ff @(posedge clock) begin
        if (sys_rst || clear) begin
            wptr_r  <= '0;
            rptr_r  <= '0;
            count_r <= '0;
        end else begin
            wptr_r  <= push ? wptr_r + AW'(1) : wptr_r;
            rptr_r  <= pop ? rptr_r + AW'(1) : rptr_r;
            count_r <= count_r + CW'(push) - CW'(pop);
        end
    end
endmodule
`default_nettype wire

// ==== rtl/tick_divider.sv ====
/*
 * One stage of the pacer: emits a one-cycle tick every DIVISOR steps.
 * Assumes step is a one-cycle enable; a divisor of zero stops the stage.
 */
`timescale 1ns/1ps
`default_nettype none
module tick_divider #(
    parameter int W = 16
) (
    input  wire logic         clock,
    input  wire logic         sys_rst,
    input  wire logic         step,
    input  wire logic [W-1:0] divisor,
    output logic              tick
);
    logic [W-1:0] count_r;
    wire          at_end = (count_r >= divisor - W'(1));

    assign tick = step & (divisor != '0) & at_end;

    always_ff @(posedge clock) begin
        if (sys_rst || divisor == '0) begin
            count_r <= '0;
        end else if (step) begin
            count_r <= at_end ? '0 : count_r + W'(1);
        end
    end
endmodule
`default_nettype wire

// ==== sim/adc_irq_fifo_readout_test.sv ====
/* Self-checking bench for the acquisition readout block.
   Assumes the package offsets and bit positions and a 50 MHz clock. */
`timescale 1ns/1ps
`default_nettype none
module adc_irq_fifo_readout_test;
    logic        clock = 1'b0;
    logic        sys_rst = 1'b1;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic        conv_start;
    logic [4:0]  conv_channel;
    logic        conv_done;
    logic [11:0] conv_result;
    logic        ext_irq_in = 1'b0;
    logic        irq_out;
    logic [3:0]  delay = 4'h0;
    logic [11:0] next_result = 12'h000;
    int          miscompares = 0;
    int          compares = 0;
    logic [31:0] d;
    int          n;

    always #10 clock = ~clock;

    adc_irq_fifo_readout u_adc_irq_fifo_readout (.clock(clock), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .conv_start(conv_start), .conv_channel(conv_channel),
        .conv_done(conv_done), .conv_result(conv_result), .ext_irq_in(ext_irq_in),
        .irq_out(irq_out));
    converter_model u_converter_model (.clock(clock), .sys_rst(sys_rst),
        .conv_start(conv_start), .delay(delay), .next_result(next_result),
        .conv_done(conv_done), .conv_result(conv_result));

    function automatic logic [31:0] word(input logic [4:0] ch, input logic [11:0] r);
        return {11'h0, ch, 4'h0, r};
    endfunction
    function automatic logic [4:0] next_ch(input logic [4:0] last, input logic [4:0] ch);
        return (ch == last) ? 5'h00 : ch + 5'h01;
    endfunction
    task automatic end_sim;
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // A gap cycle after each strobe keeps one assignment per time step
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
        @(posedge clock);
    endtask
    task automatic rd(input logic [7:0] a);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
        @(posedge clock);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        rd(a);
        chk(d, e);
    endtask
    task automatic conv(input logic [11:0] r, input logic [4:0] ch);
        next_result <= r;
        delay       <= 4'($urandom_range(7));
        wr(adc_readout_pkg::OFS_CMD, 32'h1);
        #1;
        chk(conv_channel, ch);
        n = 0;
        while (conv_done !== 1'b1 && n < 40) begin
            @(posedge clock);
            #1;
            n++;
        end
        chk(n < 40, 1'b1);
        repeat (2) @(posedge clock);
    endtask

    initial begin
        #1_000_000;
        miscompares++;
        end_sim;
    end

    initial begin
        logic [4:0]  last;
        logic [4:0]  ch;
        logic [11:0] r;
        void'($urandom(48050));
        repeat (2) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        rdc(adc_readout_pkg::OFS_CTRL, 32'h0);
        rdc(adc_readout_pkg::OFS_DIV_ONE, 32'h0);
        rdc(adc_readout_pkg::OFS_IRQ_STAT, 32'h0);
        rdc(adc_readout_pkg::OFS_IRQ_MASK, 32'h3);
        rdc(8'h24, 32'h0);
        rdc(adc_readout_pkg::OFS_STATUS, 32'h10);
        rdc(adc_readout_pkg::OFS_DATA16, 32'h0);
        $display("reset test done");
        last = 5'($urandom_range(31));
        wr(adc_readout_pkg::OFS_CTRL, {26'h0, last, 1'b0});
        for (int i = 0; i < 6; i++) begin
            r = 12'($urandom);
            conv(r, last);
            rd(adc_readout_pkg::OFS_STATUS);
            chk(d[7:6], 2'b01);
            if (i[0]) rdc(adc_readout_pkg::OFS_DATA32, word(last, r));
            else rdc(adc_readout_pkg::OFS_DATA16, {20'h0, r});
        end
        $display("fixed channel test done");
        wr(adc_readout_pkg::OFS_CTRL, 32'h7);
        ch = 5'h00;
        for (int i = 0; i < 9; i++) begin
            r = 12'($urandom);
            conv(r, ch);
            rdc(adc_readout_pkg::OFS_DATA32, word(ch, r));
            ch = next_ch(5'h03, ch);
        end
        $display("scan test done");
        wr(adc_readout_pkg::OFS_CTRL, 32'h40);
        wr(adc_readout_pkg::OFS_IRQ_STAT, 32'hF);
        conv(12'hFFF, 5'h00);
        rd(adc_readout_pkg::OFS_STATUS);
        chk(d[1:0], 2'b01);
        chk(irq_out, 1'b1);
        conv(12'h001, 5'h00);
        rd(adc_readout_pkg::OFS_IRQ_STAT);
        chk(d[0], 1'b1);
        wr(adc_readout_pkg::OFS_IRQ_STAT, 32'h1);
        rd(adc_readout_pkg::OFS_IRQ_STAT);
        chk(d[0], 1'b0);
        chk(irq_out, 1'b0);
        wr(adc_readout_pkg::OFS_IRQ_MASK, 32'h0);
        conv(12'h800, 5'h00);
        chk(irq_out, 1'b0);
        wr(adc_readout_pkg::OFS_IRQ_MASK, 32'h3);
        chk(irq_out, 1'b1);
        wr(adc_readout_pkg::OFS_IRQ_STAT, 32'hF);
        wr(adc_readout_pkg::OFS_CTRL, 32'h0);
        conv(12'h555, 5'h00);
        rd(adc_readout_pkg::OFS_IRQ_STAT);
        chk(d[0], 1'b0);
        $display("line one test done");
        wr(adc_readout_pkg::OFS_CMD, 32'h2);
        wr(adc_readout_pkg::OFS_IRQ_STAT, 32'hF);
        wr(adc_readout_pkg::OFS_CTRL, 32'h80);
        for (int i = 0; i <= adc_readout_pkg::FIFO_DEPTH; i++) begin
            conv(12'(i), 5'h00);
            if (i == 510 || i == 511) begin
                rd(adc_readout_pkg::OFS_STATUS);
                chk(d[2], i == 511);
                chk(d[0], i == 511);
            end
        end
        rd(adc_readout_pkg::OFS_STATUS);
        chk({d[5], d[3]}, 2'b11);
        rd(adc_readout_pkg::OFS_IRQ_STAT);
        chk(d[2], 1'b1);
        for (int i = 0; i < adc_readout_pkg::BLOCK_WORDS; i++) begin
            rdc(adc_readout_pkg::OFS_DATA16, 32'(i));
        end
        wr(adc_readout_pkg::OFS_CMD, 32'h2);
        rd(adc_readout_pkg::OFS_STATUS);
        chk({d[5], d[4]}, 2'b01);
        rdc(adc_readout_pkg::OFS_DATA32, 32'h0);
        $display("store test done");
        wr(adc_readout_pkg::OFS_IRQ_STAT, 32'hF);
        delay <= 4'h0;
        wr(adc_readout_pkg::OFS_DIV_ONE, 32'h3);
        wr(adc_readout_pkg::OFS_DIV_TWO, 32'h2);
        rdc(adc_readout_pkg::OFS_DIV_TWO, 32'h2);
        wr(adc_readout_pkg::OFS_CTRL, 32'h500);
        n = 0;
        while (conv_start !== 1'b1 && n < 100) begin
            @(posedge clock);
            #1;
            n++;
        end
        n = 0;
        do begin
            @(posedge clock);
            #1;
            n++;
        end while (conv_start !== 1'b1 && n < 100);
        chk(n, 6);
        @(posedge clock);
        rd(adc_readout_pkg::OFS_IRQ_STAT);
        chk(d[1], 1'b1);
        rdc(adc_readout_pkg::OFS_DATA32, word(5'h00, 12'h400));
        wr(adc_readout_pkg::OFS_DIV_ONE, 32'h0);
        repeat (10) @(posedge clock);
        wr(adc_readout_pkg::OFS_IRQ_STAT, 32'hF);
        repeat (40) @(posedge clock);
        rd(adc_readout_pkg::OFS_IRQ_STAT);
        chk(d[1], 1'b0);
        $display("pacer test done");
        wr(adc_readout_pkg::OFS_CTRL, 32'h200);
        wr(adc_readout_pkg::OFS_IRQ_STAT, 32'hF);
        ext_irq_in <= 1'b1;
        repeat (3) @(posedge clock);
        rd(adc_readout_pkg::OFS_IRQ_STAT);
        chk(d[1], 1'b1);
        chk(irq_out, 1'b1);
        // Source still high: no new rise, so the clear must stick
        wr(adc_readout_pkg::OFS_IRQ_STAT, 32'h2);
        rd(adc_readout_pkg::OFS_IRQ_STAT);
        chk(d[1], 1'b0);
        ext_irq_in <= 1'b0;
        $display("external line test done");
        end_sim;
    end
endmodule
`default_nettype wire

// ==== sim/converter_model.sv ====
/* Converter stand-in: answers each conv_start with one conv_done pulse.
   Assumes the bench sets the answer delay and the result to return. */
`timescale 1ns/1ps
`default_nettype none
module converter_model (
    input  wire logic        clock,
    input  wire logic        sys_rst,
    input  wire logic        conv_start,
    input  wire logic [3:0]  delay,
    input  wire logic [11:0] next_result,
    output logic             conv_done,
    output logic      [11:0] conv_result
);
    logic [3:0] cnt_r;
    logic       busy_r;
    logic       flip_r;
    // Result is valid only beside conv_done; it churns so stale reads show
    assign conv_result = conv_done ? next_result : (flip_r ? ~next_result : 12'hA5A);
    always @(posedge clock) begin
        flip_r    <= ~flip_r;
        conv_done <= 1'b0;
        if (sys_rst) begin
            busy_r <= 1'b0;
            flip_r <= 1'b0;
        end else if (conv_start) begin
            busy_r <= 1'b1;
            cnt_r  <= delay;
        end else if (busy_r) begin
            if (cnt_r == 4'h0) begin
                busy_r    <= 1'b0;
                conv_done <= 1'b1;
            end else begin
                cnt_r <= cnt_r - 4'h1;
            end
        end
    end
endmodule
`default_nettype wire
